// file: testbench.sv
// Self-checking bench for the queue map and VLAN entry register bank
`timescale 1ns/1ps
module testbench;
  reg ref_clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, two_queue_i = 1'b0, lkp_req_i = 1'b0;
  reg single_dest_i = 1'b0, mirror_en_i = 1'b0, mirrored_i = 1'b0;
  reg [11:0] paddr_i = 12'h000, lkp_vid_i = 12'h000;
  reg [31:0] pwdata_i = 32'h00000000;
  reg [1:0] prio_i = 2'h0;
  reg [6:0] ingress_map_i = 7'h15, cand_map_i = 7'h7F;
  wire [31:0] prdata_o;
  wire [1:0] queue_o;
  wire [6:0] member_map_o, lkp_fwd_map_o, lkp_fid_o, lkp_untag_o;
  wire [2:0] lkp_prio_o, lkp_mstp_o;
  wire pready_o, pslverr_o, member_drop_o, lkp_valid_o, lkp_hit_o, lkp_fwd_sel_o;
  integer failures = 0;
  integer cmp_count = 0;
  integer i, k;
  logic [31:0] rd;
  logic er;
  logic [11:0] ra [4] = '{12'h390, 12'h400, 12'h404, 12'h408};
  logic [31:0] rm [4] = '{32'hFF, 32'h8F00707F, 32'h7F, 32'h7F};
  logic [1:0] cs [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [1:0] th [4] = '{2'h3, 2'h2, 2'h2, 2'h1};

  vqm_regs u_vqm_regs (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .two_queue_i(two_queue_i), .prio_i(prio_i), .queue_o(queue_o),
    .single_dest_i(single_dest_i), .mirror_en_i(mirror_en_i), .mirrored_i(mirrored_i),
    .ingress_map_i(ingress_map_i), .cand_map_i(cand_map_i), .member_map_o(member_map_o),
    .member_drop_o(member_drop_o), .lkp_req_i(lkp_req_i), .lkp_vid_i(lkp_vid_i), .lkp_valid_o(lkp_valid_o),
    .lkp_hit_o(lkp_hit_o), .lkp_fwd_sel_o(lkp_fwd_sel_o), .lkp_fwd_map_o(lkp_fwd_map_o),
    .lkp_prio_o(lkp_prio_o), .lkp_mstp_o(lkp_mstp_o), .lkp_fid_o(lkp_fid_o), .lkp_untag_o(lkp_untag_o));

  // Free running 250 MHz clock
  always #2 ref_clk_i = ~ref_clk_i;

  // Verdict and end of run
  task tally_and_finish;
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Compare one value and count it
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer, waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n = n + 1;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      failures = failures + 1;
      tally_and_finish;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  // Poll the start bit until the table action is finished
  task wait_idle;
    integer n;
    n = 0;
    do begin
      apb(1'b0, 12'h40C, 32'h0);
      n = n + 1;
    end while (rd[23] !== 1'b0 && n < 3000);
    if (rd[23] !== 1'b0) begin
      failures = failures + 1;
      tally_and_finish;
    end
  endtask

  // Pulse a lookup and wait for its answer to land
  task lookup(input logic [11:0] v);
    lkp_vid_i <= v;
    lkp_req_i <= 1'b1;
    @(posedge ref_clk_i);
    lkp_req_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    for (k = 0; k < 4; k = k + 1) begin
      rdchk("reset", ra[k], (k == 0) ? 32'h82 : 32'h0);
      apb(1'b1, ra[k], 32'hFFFFFFFF);
      rdchk("ones", ra[k], rm[k]);
    end
    apb(1'b0, 12'h500, 32'h0);
    check("unmapped", {er, rd[30:0]}, 32'h80000000);
    for (k = 0; k < 4; k = k + 1) begin
      apb(1'b1, 12'h390, {24'h0, cs[k], 6'h02});
      two_queue_i <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        prio_i <= i[1:0];
        repeat (2) @(posedge ref_clk_i);
        check("queue", {30'h0, queue_o}, {31'h0, i[1:0] >= th[k]});
      end
    end
    two_queue_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    check("queue pass", {30'h0, queue_o}, 32'h3);
    single_dest_i <= 1'b1;
    mirror_en_i <= 1'b1;
    mirrored_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check("limit", {member_drop_o, member_map_o}, 32'h15);
    apb(1'b1, 12'h390, 32'h80);
    repeat (2) @(posedge ref_clk_i);
    check("drop", {member_drop_o, member_map_o}, 32'h80);
    mirrored_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    check("free", {member_drop_o, member_map_o}, 32'h7F);
    single_dest_i <= 1'b0;
    apb(1'b1, 12'h40C, 32'h00830000);
    wait_idle;
    lookup(12'h005);
    check("cleared", {lkp_valid_o, lkp_hit_o}, 32'h2);
    apb(1'b1, 12'h400, 32'h8A003015);
    apb(1'b1, 12'h404, 32'h33);
    apb(1'b1, 12'h408, 32'h55);
    apb(1'b1, 12'h40C, 32'h00810005);
    wait_idle;
    for (k = 1; k < 4; k = k + 1) apb(1'b1, ra[k], 32'h0);
    apb(1'b1, 12'h40C, 32'h00820005);
    wait_idle;
    rdchk("ent0", 12'h400, 32'h8A003015);
    rdchk("ent1", 12'h404, 32'h33);
    rdchk("ent2", 12'h408, 32'h55);
    lookup(12'h005);
    check("lookup", {lkp_valid_o, lkp_hit_o, lkp_fwd_sel_o, lkp_fwd_map_o, lkp_prio_o, lkp_mstp_o, lkp_fid_o,
      lkp_untag_o}, {2'h0, 3'h7, 7'h55, 3'h2, 3'h3, 7'h15, 7'h33});
    apb(1'b1, 12'h400, 32'h82003015);
    apb(1'b1, 12'h40C, 32'h00810006);
    wait_idle;
    apb(1'b1, 12'h40C, 32'h00800006);
    wait_idle;
    lookup(12'h006);
    check("no option", {lkp_hit_o, lkp_fwd_sel_o, lkp_fwd_map_o}, 32'h100);
    tally_and_finish;
  end
endmodule

// file: vqm_defs.vh
// Constants for the VLAN entry and queue map register bank
// Function
// - In two-queue mode the split field folds the 2-bit priority onto two queues.
// - Split code 00 sends priorities 0-2 low and 3 high.
// - Split code 10, the reset value, sends 0-1 low and 2-3 high.
// - Split code 11 sends only priority 0 low, the rest high.
// - Discard bit 1, the reset value, limits frames to ingress forwarding ports.
// - Discard bit 0 leaves single-destination frames unlimited by ingress forwarding ports.
// - Discard bit 0 with mirroring drops a single-destination frame mirrored elsewhere.
// - An entry is valid only when bit 31 of the first entry register is 1.
// - Forward-option 1 forwards matching frames to the entry forward mask.
// - Forward-option 0 leaves destination ports to other sources.
// - Each entry holds a 3-bit priority in bits 26:24.
// - Each entry holds a 3-bit spanning tree index in bits 14:12.
// - Each entry holds a 7-bit filter group ID for address table hashing.
// - A 7-bit untag mask, bit 0 for port 1, strips tags on egress.
// - A 7-bit forward mask, bit 0 for port 1, applies when forward-option set.
// - A 12-bit index register selects the table entry to access.
// - Action code: 00 none, 01 write, 10 read, 11 clear all.
// - Software sets start to launch an action; hardware clears it when finished.
`ifndef VQM_DEFS_VH
`define VQM_DEFS_VH
// Word offsets
`define VQM_OFS_QMC 12'h390
`define VQM_OFS_ENT0 12'h400
`define VQM_OFS_ENT1 12'h404
`define VQM_OFS_ENT2 12'h408
`define VQM_OFS_TIDX 12'h40C
// Queue management control fields
`define VQM_QMC_RST 8'h82
`define VQM_QMC_SPLIT_HI 7
`define VQM_QMC_SPLIT_LO 6
`define VQM_QMC_DISC 1
`define VQM_SPLIT_3H 2'h0
`define VQM_SPLIT_2H 2'h2
`define VQM_SPLIT_1H 2'h3
// Entry attribute fields
`define VQM_E0_VALID 31
`define VQM_E0_FO 27
`define VQM_E0_PRIO_LO 24
`define VQM_E0_MSTP_LO 12
`define VQM_E0_FID_LO 0
// Index word: index in 11:0, control byte in 23:16
`define VQM_TIDX_START 23
`define VQM_TIDX_ACT_LO 16
// Table actions
`define VQM_ACT_NOP 2'h0
`define VQM_ACT_WR 2'h1
`define VQM_ACT_RD 2'h2
`define VQM_ACT_CLR 2'h3
`define VQM_TBL_DEPTH 4096
`define VQM_ENT_W 29
`endif

// file: vqm_regs.v
// APB register bank for queue split, membership discard and VLAN entry staging
`timescale 1ns/1ps
`include "vqm_defs.vh"
module vqm_regs #(
  parameter IDX_W = 12,
  parameter PORTS = 7
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire two_queue_i,
  input wire [1:0] prio_i,
  output reg [1:0] queue_o,
  input wire single_dest_i,
  input wire mirror_en_i,
  input wire mirrored_i,
  input wire [PORTS-1:0] ingress_map_i,
  input wire [PORTS-1:0] cand_map_i,
  output reg [PORTS-1:0] member_map_o,
  output reg member_drop_o,
  input wire lkp_req_i,
  input wire [IDX_W-1:0] lkp_vid_i,
  output reg lkp_valid_o,
  output reg lkp_hit_o,
  output reg lkp_fwd_sel_o,
  output reg [PORTS-1:0] lkp_fwd_map_o,
  output reg [2:0] lkp_prio_o,
  output reg [2:0] lkp_mstp_o,
  output reg [6:0] lkp_fid_o,
  output reg [PORTS-1:0] lkp_untag_o
);
  localparam ENT_W = `VQM_ENT_W;

  // Control and staging registers
  reg [7:0] qmc_q;
  reg valid_q;
  reg fo_q;
  reg [2:0] prio_q;
  reg [2:0] mstp_q;
  reg [6:0] fid_q;
  reg [PORTS-1:0] untag_q;
  reg [PORTS-1:0] fwd_q;
  reg [IDX_W-1:0] idx_q;
  reg start_q;
  reg [1:0] act_q;
  reg go_q;

  wire setup;
  wire wr_en;
  wire [31:0] ent0_rd;
  wire [31:0] tidx_rd;
  wire [31:0] qmc_wr;
  wire [31:0] ent0_wr;
  wire [31:0] ent1_wr;
  wire [31:0] ent2_wr;
  wire [31:0] tidx_wr;
  reg [31:0] rdata;
  reg hit;
  wire [11:0] word_addr;

  wire tbl_done;
  wire tbl_rd_done;
  wire [ENT_W-1:0] tbl_rd_data;
  wire tbl_lkp_valid;
  wire [ENT_W-1:0] tbl_lkp_data;
  wire [ENT_W-1:0] stage_pack;
  wire lkp_ent_valid;
  wire lkp_ent_fo;
  wire [2:0] lkp_ent_prio;
  wire [2:0] lkp_ent_mstp;
  wire [6:0] lkp_ent_fid;
  wire [PORTS-1:0] lkp_ent_untag;
  wire [PORTS-1:0] lkp_ent_fwd;

  // Byte-lane merge of write data into current word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // Two-queue fold of a 2-bit priority; 1 means high queue
  function q_high;
    input [1:0] split;
    input [1:0] p;
    begin
      case (split)
        `VQM_SPLIT_3H: q_high = (p == 2'h3);
        `VQM_SPLIT_1H: q_high = (p != 2'h0);
        default: q_high = p[1];
      endcase
    end
  endfunction

  // Readback words
  // reserved read zero
  assign ent0_rd = {valid_q, 3'h0, fo_q, prio_q, 9'h000, mstp_q, 5'h00, fid_q};
  assign tidx_rd = {8'h00, start_q, 5'h00, act_q, {(16-IDX_W){1'b0}}, idx_q};

  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
  assign qmc_wr = merge({24'h000000, qmc_q}, pwdata_i, pstrb_i);
  assign ent0_wr = merge(ent0_rd, pwdata_i, pstrb_i);
  assign ent1_wr = merge({{(32-PORTS){1'b0}}, untag_q}, pwdata_i, pstrb_i);
  assign ent2_wr = merge({{(32-PORTS){1'b0}}, fwd_q}, pwdata_i, pstrb_i);
  assign tidx_wr = merge(tidx_rd, pwdata_i, pstrb_i);

  // Word-aligned address, byte lanes ignored
  assign word_addr = {paddr_i[11:2], 2'b00};

  // Address decode and read mux
  always @* begin
    rdata = 32'h00000000;
    hit = 1'b1;
    case (word_addr)
      `VQM_OFS_QMC: rdata = {24'h000000, qmc_q};
      `VQM_OFS_ENT0: rdata = ent0_rd;
      `VQM_OFS_ENT1: rdata = {{(32-PORTS){1'b0}}, untag_q};
      `VQM_OFS_ENT2: rdata = {{(32-PORTS){1'b0}}, fwd_q};
      `VQM_OFS_TIDX: rdata = tidx_rd;
      default: hit = 1'b0;
    endcase
  end

  // APB answer: ready in the first access cycle
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (ce_i) begin
      pready_o <= setup;
      if (setup) begin
        pslverr_o <= ~hit;
        prdata_o <= pwrite_i ? 32'h00000000 : rdata;
      end
    end
  end

  // Queue control, staging and table control registers
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qmc_q <= `VQM_QMC_RST;
      valid_q <= 1'b0;
      fo_q <= 1'b0;
      prio_q <= 3'h0;
      mstp_q <= 3'h0;
      fid_q <= 7'h00;
      untag_q <= {PORTS{1'b0}};
      fwd_q <= {PORTS{1'b0}};
      idx_q <= {IDX_W{1'b0}};
      start_q <= 1'b0;
      act_q <= 2'h0;
      go_q <= 1'b0;
    end else if (ce_i) begin
      go_q <= 1'b0;
      if (wr_en && hit) begin
        case (word_addr)
          `VQM_OFS_QMC: qmc_q <= qmc_wr[7:0];
          `VQM_OFS_ENT0: begin
            valid_q <= ent0_wr[`VQM_E0_VALID];
            fo_q <= ent0_wr[`VQM_E0_FO];
            prio_q <= ent0_wr[`VQM_E0_PRIO_LO +: 3];
            mstp_q <= ent0_wr[`VQM_E0_MSTP_LO +: 3];
            fid_q <= ent0_wr[`VQM_E0_FID_LO +: 7];
          end
          `VQM_OFS_ENT1: untag_q <= ent1_wr[PORTS-1:0];
          `VQM_OFS_ENT2: fwd_q <= ent2_wr[PORTS-1:0];
          // index and launch, locked while busy
          `VQM_OFS_TIDX: begin
            if (!start_q) begin
              idx_q <= tidx_wr[IDX_W-1:0];
              act_q <= tidx_wr[`VQM_TIDX_ACT_LO +: 2];
              start_q <= tidx_wr[`VQM_TIDX_START];
              go_q <= tidx_wr[`VQM_TIDX_START];
            end
          end
          default: qmc_q <= qmc_q;
        endcase
      end
      if (tbl_done) begin
        start_q <= 1'b0;
      end
      if (tbl_rd_done) begin
        {valid_q, fo_q, prio_q, mstp_q, fid_q, untag_q, fwd_q} <= tbl_rd_data;
      end
    end
  end

  assign stage_pack = {valid_q, fo_q, prio_q, mstp_q, fid_q, untag_q, fwd_q};

  // Field views of the looked-up entry, same packing as staging
  assign lkp_ent_valid = tbl_lkp_data[ENT_W-1];
  assign lkp_ent_fo = tbl_lkp_data[ENT_W-2];
  assign lkp_ent_prio = tbl_lkp_data[ENT_W-3 -: 3];
  assign lkp_ent_mstp = tbl_lkp_data[ENT_W-6 -: 3];
  assign lkp_ent_fid = tbl_lkp_data[ENT_W-9 -: 7];
  assign lkp_ent_untag = tbl_lkp_data[2*PORTS-1:PORTS];
  assign lkp_ent_fwd = tbl_lkp_data[PORTS-1:0];

  // VLAN table storage and action engine
  vqm_vlan_table #(
    .IDX_W(IDX_W),
    .DEPTH(`VQM_TBL_DEPTH),
    .ENT_W(ENT_W)
  ) u_tbl (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .go_i(go_q),
    .act_i(act_q),
    .act_idx_i(idx_q),
    .wr_data_i(stage_pack),
    .done_o(tbl_done),
    .rd_done_o(tbl_rd_done),
    .rd_data_o(tbl_rd_data),
    .lkp_req_i(lkp_req_i),
    .lkp_idx_i(lkp_vid_i),
    .lkp_valid_o(tbl_lkp_valid),
    .lkp_data_o(tbl_lkp_data)
  );

  // Queue fold and membership filtering
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      queue_o <= 2'h0;
      member_map_o <= {PORTS{1'b0}};
      member_drop_o <= 1'b0;
    end else if (ce_i) begin
      if (two_queue_i) begin
        queue_o <= {1'b0, q_high(qmc_q[`VQM_QMC_SPLIT_HI:`VQM_QMC_SPLIT_LO], prio_i)};
      end else begin
        queue_o <= prio_i;
      end
      member_drop_o <= 1'b0;
      if (qmc_q[`VQM_QMC_DISC] || !single_dest_i) begin
        member_map_o <= cand_map_i & ingress_map_i;
      end else if (mirror_en_i && mirrored_i) begin
        member_map_o <= {PORTS{1'b0}};
        member_drop_o <= 1'b1;
      end else begin
        member_map_o <= cand_map_i;
      end
    end
  end

  // Lookup result, masked by entry validity
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lkp_valid_o <= 1'b0;
      lkp_hit_o <= 1'b0;
      lkp_fwd_sel_o <= 1'b0;
      lkp_fwd_map_o <= {PORTS{1'b0}};
      lkp_prio_o <= 3'h0;
      lkp_mstp_o <= 3'h0;
      lkp_fid_o <= 7'h00;
      lkp_untag_o <= {PORTS{1'b0}};
    end else if (ce_i) begin
      lkp_valid_o <= tbl_lkp_valid;
      lkp_hit_o <= lkp_ent_valid;
      lkp_fwd_sel_o <= lkp_ent_valid & lkp_ent_fo;
      // mask used only with option set
      lkp_fwd_map_o <= (lkp_ent_valid & lkp_ent_fo) ? lkp_ent_fwd : {PORTS{1'b0}};
      if (lkp_ent_valid) begin
        lkp_prio_o <= lkp_ent_prio;
        lkp_mstp_o <= lkp_ent_mstp;
        lkp_fid_o <= lkp_ent_fid;
        lkp_untag_o <= lkp_ent_untag;
      end else begin
        lkp_prio_o <= 3'h0;
        lkp_mstp_o <= 3'h0;
        lkp_fid_o <= 7'h00;
        lkp_untag_o <= {PORTS{1'b0}};
      end
    end
  end
endmodule

// file: vqm_regs_props.sv
// Assertion checker for the queue map and VLAN entry register bank
`timescale 1ns/1ps
module vqm_regs_chk #(
  parameter IDX_W = 12,
  parameter PORTS = 7
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire two_queue_i,
  input wire [1:0] prio_i,
  input wire [1:0] queue_o,
  input wire single_dest_i,
  input wire mirror_en_i,
  input wire mirrored_i,
  input wire [PORTS-1:0] ingress_map_i,
  input wire [PORTS-1:0] cand_map_i,
  input wire [PORTS-1:0] member_map_o,
  input wire member_drop_o,
  input wire lkp_req_i,
  input wire lkp_valid_o,
  input wire lkp_hit_o,
  input wire lkp_fwd_sel_o,
  input wire [PORTS-1:0] lkp_fwd_map_o,
  input wire [2:0] lkp_prio_o,
  input wire [2:0] lkp_mstp_o,
  input wire [6:0] lkp_fid_o,
  input wire [PORTS-1:0] lkp_untag_o
);
  // Decode of the five mapped words
  wire mapped = (paddr_i[11:2] == 10'h0E4) || (paddr_i[11:4] == 8'h40);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i || !ce_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_lkp_answer;
    ##2 lkp_valid_o;
  endsequence
  chk_ready_pulse: assert property (s_setup |=> pready_o ##1 !pready_o)
    else $error("ready is not one pulse after setup");
  chk_err_unmapped: assert property (pready_o && !mapped |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pready_o && mapped |-> !pslverr_o)
    else $error("mapped access flagged as error");
  chk_mask_resvd: assert property (pready_o && !pwrite_i && paddr_i[11:2] inside {10'h101, 10'h102}
    |-> prdata_o[31:7] == 25'h0)
    else $error("mask word reserved bits not zero");
  chk_attr_resvd: assert property (pready_o && !pwrite_i && paddr_i[11:2] == 10'h100
    |-> (prdata_o & 32'h70FF8F80) == 32'h0)
    else $error("attribute reserved bits not zero");
  chk_fold_two: assert property (two_queue_i |=> queue_o[1] == 1'b0)
    else $error("two queue result out of range");
  chk_prio_ends: assert property (two_queue_i && prio_i inside {2'h0, 2'h3}
    |=> queue_o == {1'b0, $past(prio_i[1])})
    else $error("lowest or highest priority misplaced");
  chk_multi_dest: assert property (!single_dest_i |=> member_map_o == $past(cand_map_i & ingress_map_i))
    else $error("multi destination map not limited");
  chk_drop_empty: assert property (member_drop_o
    |-> member_map_o == '0 && $past(single_dest_i && mirror_en_i && mirrored_i))
    else $error("drop without mirrored single destination");
  chk_lkp_answer: assert property (lkp_req_i |-> s_lkp_answer)
    else $error("lookup answer late");
  chk_fwd_gated: assert property (lkp_valid_o |-> (lkp_fwd_sel_o ? lkp_hit_o : lkp_fwd_map_o == '0))
    else $error("forward map not gated by option");
  chk_invalid_blank: assert property (lkp_valid_o && !lkp_hit_o
    |-> {lkp_prio_o, lkp_mstp_o, lkp_fid_o, lkp_untag_o} == '0)
    else $error("invalid entry fields not zero");
endmodule
bind vqm_regs vqm_regs_chk #(.IDX_W(IDX_W), .PORTS(PORTS)) u_vqm_regs_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .two_queue_i(two_queue_i), .prio_i(prio_i), .queue_o(queue_o), .single_dest_i(single_dest_i),
  .mirror_en_i(mirror_en_i), .mirrored_i(mirrored_i), .ingress_map_i(ingress_map_i), .cand_map_i(cand_map_i),
  .member_map_o(member_map_o), .member_drop_o(member_drop_o), .lkp_req_i(lkp_req_i), .lkp_valid_o(lkp_valid_o),
  .lkp_hit_o(lkp_hit_o), .lkp_fwd_sel_o(lkp_fwd_sel_o), .lkp_fwd_map_o(lkp_fwd_map_o), .lkp_prio_o(lkp_prio_o),
  .lkp_mstp_o(lkp_mstp_o), .lkp_fid_o(lkp_fid_o), .lkp_untag_o(lkp_untag_o));

// file: vqm_vlan_table.v
// VLAN table storage with action engine and lookup port
`timescale 1ns/1ps
`include "vqm_defs.vh"
module vqm_vlan_table #(
  parameter IDX_W = 12,
  parameter DEPTH = `VQM_TBL_DEPTH,
  parameter ENT_W = `VQM_ENT_W
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire go_i,
  input wire [1:0] act_i,
  input wire [IDX_W-1:0] act_idx_i,
  input wire [ENT_W-1:0] wr_data_i,
  output reg done_o,
  output reg rd_done_o,
  output reg [ENT_W-1:0] rd_data_o,
  input wire lkp_req_i,
  input wire [IDX_W-1:0] lkp_idx_i,
  output reg lkp_valid_o,
  output reg [ENT_W-1:0] lkp_data_o
);
  reg [ENT_W-1:0] mem [0:DEPTH-1];
  reg clr_q;
  reg [IDX_W-1:0] cnt_q;
  wire we;
  wire [IDX_W-1:0] wa;
  wire [ENT_W-1:0] wd;

  // Single write port shared by write and clear actions
  assign we = clr_q | (go_i & (act_i == `VQM_ACT_WR));
  assign wa = clr_q ? cnt_q : act_idx_i;
  assign wd = clr_q ? {ENT_W{1'b0}} : wr_data_i;

  // Memory write and both read ports
  always @(posedge ref_clk_i) begin
    if (ce_i) begin
      if (we) begin
        mem[wa] <= wd;
      end
      rd_data_o <= mem[act_idx_i];
      lkp_data_o <= mem[lkp_idx_i];
    end
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clr_q <= 1'b0;
      cnt_q <= {IDX_W{1'b0}};
      done_o <= 1'b0;
      rd_done_o <= 1'b0;
      lkp_valid_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      rd_done_o <= 1'b0;
      lkp_valid_o <= lkp_req_i;
      if (clr_q) begin
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q == DEPTH[IDX_W-1:0] - 1'b1 || &cnt_q) begin
          clr_q <= 1'b0;
          done_o <= 1'b1;
        end
      end else if (go_i) begin
        if (act_i == `VQM_ACT_CLR) begin
          clr_q <= 1'b1;
          cnt_q <= {IDX_W{1'b0}};
        end else begin
          done_o <= 1'b1;
          rd_done_o <= (act_i == `VQM_ACT_RD);
        end
      end
    end
  end
endmodule
